// file: pdvr_pkg.sv
// Function
// - doubler select 1 doubler, 0 divider path
// - cal clock divided by 1,2,4,8
// - 12-bit feedback divider split over two registers
// - feedback divider double-buffered, applied whole
// - reference divider six bits, resets to 1
// - core override selects one of four cores
// - core code 00 lowest, 11 highest frequency
// - bias override applies bias 0 to 15
// - band override selects one of 256 bands
// - band code 0 highest, 255 lowest frequency
// - feedback lower byte resets to 0x80
package pdvr_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] PDVR_ADDR_FB_LOW   = 8'h10;
    localparam logic [7:0] PDVR_ADDR_FB_HIGH  = 8'h11;
    localparam logic [7:0] PDVR_ADDR_OUT_REF  = 8'h12;
    localparam logic [7:0] PDVR_ADDR_CORE_BIAS = 8'h13;
    localparam logic [7:0] PDVR_ADDR_BAND     = 8'h14;

    // ==========================================================
    // reset values
    localparam logic [7:0] PDVR_RST_FB_LOW    = 8'h80;
    localparam logic [7:0] PDVR_RST_FB_HIGH   = 8'h00;
    localparam logic [7:0] PDVR_RST_OUT_REF   = 8'h01;
    localparam logic [7:0] PDVR_RST_CORE_BIAS = 8'h00;
    localparam logic [7:0] PDVR_RST_BAND      = 8'h00;
    localparam logic [7:0] PDVR_READ_NONE     = 8'h00;

    // ==========================================================
    // field positions
    localparam int PDVR_CAL_EN_BIT      = 7;
    localparam int PDVR_DBLR_BIT        = 6;
    localparam int PDVR_CALDIV_HI       = 5;
    localparam int PDVR_CALDIV_LO       = 4;
    localparam int PDVR_FBHI_HI         = 3;
    localparam int PDVR_FBHI_LO         = 0;
    localparam int PDVR_OUTDIV_HI       = 7;
    localparam int PDVR_OUTDIV_LO       = 6;
    localparam int PDVR_REFDIV_HI       = 5;
    localparam int PDVR_REFDIV_LO       = 0;
    localparam int PDVR_CORE_HI         = 5;
    localparam int PDVR_CORE_LO         = 4;
    localparam int PDVR_BIAS_HI         = 3;
    localparam int PDVR_BIAS_LO         = 0;

    // ==========================================================
    // calibration clock divider codes and terminal counts
    localparam logic [1:0] PDVR_CALDIV_1    = 2'h0;
    localparam logic [1:0] PDVR_CALDIV_2    = 2'h1;
    localparam logic [1:0] PDVR_CALDIV_4    = 2'h2;
    localparam logic [1:0] PDVR_CALDIV_8    = 2'h3;
    localparam logic [2:0] PDVR_CALTC_1     = 3'h0;
    localparam logic [2:0] PDVR_CALTC_2     = 3'h1;
    localparam logic [2:0] PDVR_CALTC_4     = 3'h3;
    localparam logic [2:0] PDVR_CALTC_8     = 3'h7;
    localparam logic [2:0] PDVR_CALCNT_ZERO = 3'h0;
    localparam logic [2:0] PDVR_CALCNT_ONE  = 3'h1;

    // ==========================================================
    // whole block state
    typedef struct packed {
        logic [7:0]  fb_low;      // feedback lower byte, subordinate
        logic [7:0]  fb_high;     // cal enable, doubler, cal div, feedback upper, subordinate
        logic [11:0] fb_main;     // feedback divider in use
        logic [7:0]  out_ref;
        logic [7:0]  core_bias;
        logic [7:0]  band;
        logic [7:0]  rdata;
        logic [2:0]  cal_cnt;
        logic        cal_tick;
        logic [1:0]  act_core;
        logic [3:0]  act_bias;
        logic [7:0]  act_band;
    } pdvr_state_t;

endpackage

// file: pdvr_regs.sv
`timescale 1ns/10ps
module pdvr_regs
    import pdvr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        MAIN_READBACK,
    input  wire logic        CORE_OVERRIDE,
    input  wire logic        BIAS_OVERRIDE,
    input  wire logic        BAND_OVERRIDE,
    input  wire logic [1:0]  CAL_CORE,
    input  wire logic [3:0]  CAL_BIAS,
    input  wire logic [7:0]  CAL_BAND,
    output logic             CAL_ENABLE,
    output logic             REF_DOUBLER_SEL,
    output logic             CAL_CLK_TICK,
    output logic      [11:0] FEEDBACK_DIV,
    output logic      [1:0]  OUT_CLK_DIV,
    output logic      [5:0]  REF_DIV,
    output logic      [1:0]  ACTIVE_CORE,
    output logic      [3:0]  ACTIVE_BIAS,
    output logic      [7:0]  ACTIVE_BAND
);

    // ==========================================================
    // state
    pdvr_state_t st;
    pdvr_state_t next_st;

    // ==========================================================
    // next state
    // all register inputs come from the serial engine on CLK,
    // so no synchroniser sits in front of them
    always_comb begin
        logic [2:0] cal_tc;
        logic [7:0] rd_val;
        cal_tc = PDVR_CALTC_1;
        rd_val = PDVR_READ_NONE;
        next_st = st;

        // register writes
        if (REG_WR) begin
            unique case (REG_ADDR)
                PDVR_ADDR_FB_LOW: begin
                    next_st.fb_low = REG_WDATA;
                    // lower byte write commits both halves at once,
                    // so the divider never runs half-updated
                    next_st.fb_main = {st.fb_high[PDVR_FBHI_HI:PDVR_FBHI_LO],
                                       REG_WDATA};
                end
                PDVR_ADDR_FB_HIGH: begin
                    next_st.fb_high = REG_WDATA;
                end
                PDVR_ADDR_OUT_REF: begin
                    next_st.out_ref = REG_WDATA;
                end
                PDVR_ADDR_CORE_BIAS: begin
                    next_st.core_bias = REG_WDATA;
                end
                PDVR_ADDR_BAND: begin
                    next_st.band = REG_WDATA;
                end
                default: begin
                    next_st.band = st.band; // unmapped writes are dropped
                end
            endcase
        end

        // register reads, answered one cycle later
        unique case (REG_ADDR)
            PDVR_ADDR_FB_LOW: begin
                rd_val = MAIN_READBACK ? st.fb_main[7:0] : st.fb_low;
            end
            PDVR_ADDR_FB_HIGH: begin
                rd_val = st.fb_high;
                if (MAIN_READBACK) begin
                    rd_val[PDVR_FBHI_HI:PDVR_FBHI_LO] = st.fb_main[11:8];
                end
            end
            PDVR_ADDR_OUT_REF: begin
                rd_val = st.out_ref;
            end
            PDVR_ADDR_CORE_BIAS: begin
                rd_val = st.core_bias;
            end
            PDVR_ADDR_BAND: begin
                rd_val = st.band;
            end
            default: begin
                rd_val = PDVR_READ_NONE;
            end
        endcase
        if (REG_RD) begin
            next_st.rdata = rd_val;
        end

        // calibration clock divider: one-cycle enable every 1,2,4,8 cycles
        unique case (st.fb_high[PDVR_CALDIV_HI:PDVR_CALDIV_LO])
            PDVR_CALDIV_1: cal_tc = PDVR_CALTC_1;
            PDVR_CALDIV_2: cal_tc = PDVR_CALTC_2;
            PDVR_CALDIV_4: cal_tc = PDVR_CALTC_4;
            PDVR_CALDIV_8: cal_tc = PDVR_CALTC_8;
        endcase
        // >= rather than == so a shrinking code never strands the count
        if (st.cal_cnt >= cal_tc) begin
            next_st.cal_cnt = PDVR_CALCNT_ZERO;
            next_st.cal_tick = 1'b1;
        end else begin
            next_st.cal_cnt = st.cal_cnt + PDVR_CALCNT_ONE;
            next_st.cal_tick = 1'b0;
        end

        // oscillator selection: manual field or calibration result
        next_st.act_core = CORE_OVERRIDE ?
            st.core_bias[PDVR_CORE_HI:PDVR_CORE_LO] : CAL_CORE;
        next_st.act_bias = BIAS_OVERRIDE ?
            st.core_bias[PDVR_BIAS_HI:PDVR_BIAS_LO] : CAL_BIAS;
        next_st.act_band = BAND_OVERRIDE ? st.band : CAL_BAND;
    end

    // ==========================================================
    // state register, synchronous reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st.fb_low    <= PDVR_RST_FB_LOW;
            st.fb_high   <= PDVR_RST_FB_HIGH;
            st.fb_main   <= {PDVR_RST_FB_HIGH[PDVR_FBHI_HI:PDVR_FBHI_LO],
                             PDVR_RST_FB_LOW};
            st.out_ref   <= PDVR_RST_OUT_REF;
            st.core_bias <= PDVR_RST_CORE_BIAS;
            st.band      <= PDVR_RST_BAND;
            st.rdata     <= PDVR_READ_NONE;
            st.cal_cnt   <= PDVR_CALCNT_ZERO;
            st.cal_tick  <= 1'b0;
            st.act_core  <= PDVR_RST_CORE_BIAS[PDVR_CORE_HI:PDVR_CORE_LO];
            st.act_bias  <= PDVR_RST_CORE_BIAS[PDVR_BIAS_HI:PDVR_BIAS_LO];
            st.act_band  <= PDVR_RST_BAND;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs, all straight from flip-flops
    assign REG_RDATA       = st.rdata;
    assign CAL_ENABLE      = st.fb_high[PDVR_CAL_EN_BIT];
    assign REF_DOUBLER_SEL = st.fb_high[PDVR_DBLR_BIT];
    assign CAL_CLK_TICK    = st.cal_tick;
    assign FEEDBACK_DIV    = st.fb_main;
    assign OUT_CLK_DIV     = st.out_ref[PDVR_OUTDIV_HI:PDVR_OUTDIV_LO];
    assign REF_DIV         = st.out_ref[PDVR_REFDIV_HI:PDVR_REFDIV_LO];
    assign ACTIVE_CORE     = st.act_core;
    assign ACTIVE_BIAS     = st.act_bias;
    assign ACTIVE_BAND     = st.act_band;

endmodule

// file: pdvr_regs_sva.sv
`timescale 1ns/10ps
module pdvr_regs_sva
    import pdvr_pkg::*;
(
    input wire logic        CLK, RESET, REG_WR, CORE_OVERRIDE, BAND_OVERRIDE,
    input wire logic        REF_DOUBLER_SEL, CAL_CLK_TICK,
    input wire logic [7:0]  REG_ADDR, REG_WDATA, CAL_BAND, ACTIVE_BAND,
    input wire logic [1:0]  CAL_CORE, ACTIVE_CORE,
    input wire logic [5:0]  REF_DIV,
    input wire logic [11:0] FEEDBACK_DIV
);
    // ==========================================================
    // mirror of the cal divider code, so tick spacing can be judged
    logic [1:0] cd;
    always_ff @(posedge CLK) begin
        if (RESET)
            cd <= 2'h0;
        else if (REG_WR && REG_ADDR == PDVR_ADDR_FB_HIGH)
            cd <= REG_WDATA[5:4];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // ==========================================================
    // register effects
    AST_DBLR: assert property (REG_WR && REG_ADDR == PDVR_ADDR_FB_HIGH
        |=> REF_DOUBLER_SEL == $past(REG_WDATA[6])) else $error("doubler select wrong");
    AST_FB_HOLD: assert property (REG_WR && REG_ADDR == PDVR_ADDR_FB_HIGH
        |=> $stable(FEEDBACK_DIV)) else $error("divider moved on upper write");
    AST_FB_LOW: assert property (REG_WR && REG_ADDR == PDVR_ADDR_FB_LOW
        |=> FEEDBACK_DIV[7:0] == $past(REG_WDATA)) else $error("divider not committed");
    AST_REFDIV: assert property (REG_WR && REG_ADDR == PDVR_ADDR_OUT_REF
        |=> REF_DIV == $past(REG_WDATA[5:0])) else $error("reference divider wrong");
    // calibration results pass when override is off
    AST_CORE_CAL: assert property (!CORE_OVERRIDE
        |=> ACTIVE_CORE == $past(CAL_CORE)) else $error("core not from calibration");
    AST_BAND_CAL: assert property (!BAND_OVERRIDE
        |=> ACTIVE_BAND == $past(CAL_BAND)) else $error("band not from calibration");
    // tick spacing only judged while the code holds still
    AST_TICK_DIV1: assert property ((cd == 2'h0)[*3] |-> CAL_CLK_TICK)
        else $error("tick missing at divide by 1");
    AST_TICK_DIV8: assert property ((CAL_CLK_TICK && cd == 2'h3) ##1
        (!CAL_CLK_TICK && cd == 2'h3)[*7] |=> CAL_CLK_TICK) else $error("tick late at 8");
endmodule
bind pdvr_regs pdvr_regs_sva u_pdvr_regs_sva(.*);

// file: pdvr_host.sv
`timescale 1ns/10ps
module pdvr_host (
    input  wire logic       clk,
    output logic      [7:0] addr, wdata,
    output logic            wr, rd
);
    initial begin
        {addr, wdata, wr, rd} = 18'h0;
    end
    // ==========================================================
    // one request per call, launched and released on falling edges
    task automatic op(input logic w, r, input logic [7:0] a, d);
        @(negedge clk);
        {wr, rd, addr, wdata} = {w, r, a, d};
        @(negedge clk);
        {wr, rd} = 2'h0;
        {addr, wdata} = {~a, ~d}; // released lines show a changing pattern
    endtask
    // upper part first, lower byte commits the whole divider
    task automatic fb(input logic [11:0] n);
        logic [11:0] v;
        v = (n < 12'h002) ? 12'h002 : n;
        op(1'b1, 1'b0, 8'h11, {4'h0, v[11:8]});
        op(1'b1, 1'b0, 8'h10, v[7:0]);
    endtask
endmodule

// file: pdvr_regs_tb.sv
`timescale 1ns/10ps
module pdvr_regs_tb;
    import pdvr_pkg::*;
    logic CLK = 0, RESET = 1, MAIN_READBACK = 0, REG_WR, REG_RD, CAL_ENABLE, REF_DOUBLER_SEL;
    logic CORE_OVERRIDE = 0, BIAS_OVERRIDE = 0, BAND_OVERRIDE = 0, CAL_CLK_TICK;
    logic [1:0]  CAL_CORE = 0, OUT_CLK_DIV, ACTIVE_CORE;
    logic [3:0]  CAL_BIAS = 0, ACTIVE_BIAS;
    logic [7:0]  CAL_BAND = 0, REG_ADDR, REG_WDATA, REG_RDATA, ACTIVE_BAND, d, b;
    logic [11:0] FEEDBACK_DIV, q[$];
    logic [5:0]  REF_DIV;
    logic [31:0] seed = 32'd76;
    logic [7:0]  rst[5] = '{PDVR_RST_FB_LOW, PDVR_RST_FB_HIGH, PDVR_RST_OUT_REF, 8'h00, 8'h00};
    logic [11:0] fbv[3] = '{12'h002, 12'hfff, 12'h123};
    int err_count = 0, comparisons = 0, n;
    pdvr_regs u_pdvr_regs(.*);
    pdvr_host u_pdvr_host(.clk(CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD));
    initial forever #10 CLK = ~CLK;
    // ==========================================================
    // helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input string s, input logic [11:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, e);
        q.push_back({4'h0, e});
        u_pdvr_host.op(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, v);
        u_pdvr_host.op(1'b1, 1'b0, a, v);
    endtask
    // bounded wait for the next cal tick, counting falling edges
    task automatic wtick(output int c);
        c = 0;
        do begin
            @(negedge CLK);
            c++;
        end while (!CAL_CLK_TICK && c < 20);
        if (c >= 20) begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // read data lands one cycle after the strobe, compared with the oldest note
    initial forever begin
        @(posedge CLK);
        if (REG_RD === 1'b1) begin
            @(negedge CLK);
            chk("read data", q.pop_front(), {4'h0, REG_RDATA});
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(negedge CLK);
        RESET = 0;
        foreach (rst[i]) rd(8'h10 + 8'(i), rst[i]);
        chk("divider", 12'h080, FEEDBACK_DIV);
        wr(8'h20, 8'h5a);
        rd(8'h20, PDVR_READ_NONE);
        $display("reset test done");
        foreach (fbv[i]) begin
            u_pdvr_host.fb(fbv[i]);
            chk("divider", fbv[i], FEEDBACK_DIV);
        end
        wr(8'h11, 8'h0f);
        chk("divider held", fbv[2], FEEDBACK_DIV);
        MAIN_READBACK = 1;
        rd(8'h11, {4'h0, fbv[2][11:8]});
        MAIN_READBACK = 0;
        rd(8'h11, 8'h0f);
        $display("feedback test done");
        for (int c = 0; c < 4; c++) begin
            d = rnd();
            d[5:0] = {c[1:0], 4'h0};
            wr(8'h11, d);
            chk("doubler", {11'h0, d[6]}, {11'h0, REF_DOUBLER_SEL});
            chk("cal enable", {11'h0, d[7]}, {11'h0, CAL_ENABLE});
            wtick(n);
            wtick(n);
            chk("tick period", 12'(1 << c), n[11:0]);
        end
        d = rnd();
        wr(8'h12, d);
        chk("ref div", {6'h0, d[5:0]}, {6'h0, REF_DIV});
        chk("out div", {10'h0, d[7:6]}, {10'h0, OUT_CLK_DIV});
        rd(8'h12, d);
        $display("control test done");
        // every core and bias code, random band, flags and cal results
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            {CORE_OVERRIDE, BIAS_OVERRIDE, BAND_OVERRIDE} = d[2:0];
            {CAL_CORE, CAL_BIAS} = d[7:2];
            CAL_BAND = rnd();
            b = rnd();
            wr(8'h13, {2'h2, i[1:0], i[3:0]});
            wr(8'h14, b);
            @(negedge CLK);
            chk("core", CORE_OVERRIDE ? 12'(i[1:0]) : 12'(CAL_CORE), 12'(ACTIVE_CORE));
            chk("bias", BIAS_OVERRIDE ? 12'(i[3:0]) : 12'(CAL_BIAS), 12'(ACTIVE_BIAS));
            chk("band", BAND_OVERRIDE ? 12'(b) : 12'(CAL_BAND), 12'(ACTIVE_BAND));
        end
        rd(8'h13, 8'hbf);
        rd(8'h14, b);
        $display("override test done");
        repeat (3) @(negedge CLK);
        stop_test();
    end
endmodule
